/* logic/aipb_map.svh */
`ifndef AIPB_MAP_SVH
`define AIPB_MAP_SVH

// Fixed header values of the audio description packet.
`define AIPB_PKT_TYPE    8'h84
`define AIPB_PKT_VER     8'h01
`define AIPB_PKT_LEN     8'h0A

// Packet geometry: three header bytes, then checksum and payload.
`define AIPB_NUM_BYTES   31
`define AIPB_IDX_W       5
`define AIPB_LAST_IDX    5'h1E
`define AIPB_FIRST_IDX   5'h00
`define AIPB_HB0         0
`define AIPB_HB1         1
`define AIPB_HB2         2
`define AIPB_PB(n)       (3 + (n))

// Field values and small constants.
`define AIPB_ZERO8       8'h00
`define AIPB_ZERO4       4'h0
`define AIPB_ZERO3       3'h0
`define AIPB_ZERO2       2'h0
`define AIPB_SF_REFER    3'h0
`define AIPB_MISS_FIELDS 2'h2
`define AIPB_FCNT_ONE    2'h1

`endif

/* logic/aipb_pkg.sv */
package aipb_pkg;

    // Kind of audio stream being carried.
    typedef enum logic [1:0] {
        AIPB_LPCM   = 2'h0,
        AIPB_BURST  = 2'h1,
        AIPB_ONEBIT = 2'h2,
        AIPB_DST    = 2'h3
    } aipb_kind_t;

    // Core side launch machine.
    typedef enum logic [1:0] {
        C_IDLE = 2'b01,
        C_WAIT = 2'b10
    } aipb_cst_t;

    // Link side byte sender.
    typedef enum logic [2:0] {
        L_IDLE = 3'b001,
        L_WAIT = 3'b010,
        L_SEND = 3'b100
    } aipb_lst_t;

    // True for streams whose sample rate comes from clock regeneration.
    function automatic logic aipb_fs_from_acr(input aipb_kind_t k);
        return (k == AIPB_ONEBIT) || (k == AIPB_DST);
    endfunction

endpackage

/* logic/aipb_if.sv */
`timescale 1ns/1ps
`include "aipb_map.svh"

// Descriptor fields in, assembled packet bytes out.
interface aipb_if;
    import aipb_pkg::*;
    aipb_kind_t                     kind;
    logic [2:0]                     chan;
    logic [2:0]                     acr_fs;
    logic [7:0]                     spk;
    logic [3:0]                     lsv;
    logic                           dmi;
    logic                           disc;
    logic [`AIPB_NUM_BYTES-1:0][7:0] pkt;

    modport src (output kind, chan, acr_fs, spk, lsv, dmi, disc, input pkt);
    modport bld (input kind, chan, acr_fs, spk, lsv, dmi, disc, output pkt);
endinterface

/* logic/aipb_builder.sv */
`timescale 1ns/1ps
`include "aipb_map.svh"

module aipb_builder (
    aipb_if.bld b    // Descriptors in, packet out.
);
    import aipb_pkg::*;

    wire [`AIPB_NUM_BYTES-1:0][7:0] bytes;
    wire [2:0]                      sf;
    wire [7:0]                      byte_sum;
    wire                            dmi_out;

    // Sample rate is only named for regenerated-clock streams.
    assign sf = aipb_fs_from_acr(b.kind) ? b.acr_fs : `AIPB_SF_REFER; // [R11] [R12] [R13]

    // Inhibit is only passed through for disc audio.
    assign dmi_out = b.disc & b.dmi; // [R17]

    // Fixed header.
    assign bytes[`AIPB_HB0] = `AIPB_PKT_TYPE; // [R7]
    assign bytes[`AIPB_HB1] = `AIPB_PKT_VER;  // [R7]
    assign bytes[`AIPB_HB2] = `AIPB_PKT_LEN;  // [R7]

    // Payload: zero fields defer to the stream's own headers.
    assign bytes[`AIPB_PB(1)] = {`AIPB_ZERO4, 1'b0, b.chan}; // [R9] [R14] [R8] [R6]
    assign bytes[`AIPB_PB(2)] = {`AIPB_ZERO3, sf, `AIPB_ZERO2}; // [R10] [R20]
    assign bytes[`AIPB_PB(3)] = `AIPB_ZERO8; // [R18]
    assign bytes[`AIPB_PB(4)] = b.spk; // [R15]
    assign bytes[`AIPB_PB(5)] = {dmi_out, b.lsv, `AIPB_ZERO3}; // [R16]

    // Reserved payload bytes six onward.
    genvar gi;
    generate
        for (gi = `AIPB_PB(6); gi < `AIPB_NUM_BYTES; gi = gi + 1) begin : g_zero
            assign bytes[gi] = `AIPB_ZERO8; // [R20]
        end
    endgenerate

    // Checksum makes the whole packet sum to zero.
    assign byte_sum = bytes[`AIPB_HB0] + bytes[`AIPB_HB1] + bytes[`AIPB_HB2]
                    + bytes[`AIPB_PB(1)] + bytes[`AIPB_PB(2)] + bytes[`AIPB_PB(3)]
                    + bytes[`AIPB_PB(4)] + bytes[`AIPB_PB(5)];
    assign bytes[`AIPB_PB(0)] = `AIPB_ZERO8 - byte_sum; // [R19]

    assign b.pkt = bytes;

endmodule // aipb_builder

/* logic/aipb_top.sv */
// Contract
// (R1) Send packet at least every two fields.
// (R2) Changed packet within one field of change.
// (R3) Prefer packet before first affected sample.
// (R4) One-bit audio: packet strictly before sample.
// (R5) Send in any auxiliary data period.
// (R6) Packet plus stream headers describe audio.
// (R7) Header bytes 0x84, 0x01, 0x0A.
// (R8) Zero field means see stream headers.
// (R9) Coding type always zero.
// (R10) Sample size always zero.
// (R11) Sample rate zero for PCM and bursts.
// (R12) One-bit and DST: rate from clock regeneration.
// (R13) One-bit disc typically uses code 010.
// (R14) Channel count in bits 2:0, bit3 zero.
// (R15) Speaker map byte four, invalid for bursts.
// (R16) Level shift bits 6:3, low bits zero.
// (R17) Downmix inhibit only for disc audio.
// (R18) Payload byte three always zero.
// (R19) Checksum makes packet sum zero.
// (R20) Remaining reserved bytes are zero.
`timescale 1ns/1ps
`include "aipb_map.svh"

module aipb_top (
    input  wire logic                 MCLK_I,             // Core clock, 10 MHz.
    input  wire logic                 RESET_I,            // Synchronous reset, high.
    input  wire logic                 LINK_CLK_I,         // Link-side clock.
    input  wire logic                 STREAM_ACTIVE_I,    // Audio stream running.
    input  wire aipb_pkg::aipb_kind_t AUDIO_KIND_I,       // Stream kind.
    input  wire logic [2:0]           CHANNEL_COUNT_I,    // Channel count code.
    input  wire logic [2:0]           ACR_FS_I,           // Regenerated rate code.
    input  wire logic [7:0]           SPEAKER_MAP_I,      // Speaker allocation.
    input  wire logic [3:0]           LEVEL_SHIFT_I,      // Downmix level shift.
    input  wire logic                 DOWNMIX_INHIBIT_I,  // Stream inhibit flag.
    input  wire logic                 DISC_AUDIO_I,       // Disc playback mode.
    input  wire logic                 PREFER_HOLD_I,      // Hold all kinds on change.
    input  wire logic                 FIELD_START_I,      // Pulse per video field.
    input  wire logic                 SAMPLE_SENT_I,      // A sample went out.
    input  wire logic                 SAMPLE_NONSILENT_I, // That sample is audible.
    input  wire logic                 ISLAND_OPEN_I,      // Packet slot, link clock.
    output logic                      SAMPLE_HOLD_O,      // Stall audio samples.
    output logic                      UPDATE_PENDING_O,   // Changed packet not out.
    output logic                      DEADLINE_MISS_O,    // Update came too late.
    output logic                      PKT_BUSY_O,         // Packet in flight.
    output logic                      LINK_VALID_O,       // Byte valid, link clock.
    output logic [7:0]                LINK_BYTE_O,        // Packet byte.
    output logic                      LINK_FIRST_O,       // First byte flag.
    output logic                      LINK_LAST_O         // Last byte flag.
);
    import aipb_pkg::*;

    aipb_if bif ();

    // Core-domain state.
    logic [`AIPB_NUM_BYTES-1:0][7:0] pkt_sent;
    logic [`AIPB_NUM_BYTES-1:0][7:0] pkt_done;
    logic                            active_q;
    logic                            stream_new;
    logic                            due;
    logic                            armed;
    logic [1:0]                      fcnt;
    logic                            req_tgl;
    logic                            ack_m;
    logic                            ack_s;
    logic                            ack_seen;
    aipb_cst_t                       cst;

    // Link-domain state.
    logic                            lrst_m;
    logic                            lrst;
    logic                            req_m;
    logic                            req_s;
    logic                            req_seen;
    logic                            ack_tgl;
    logic [`AIPB_IDX_W-1:0]          idx;
    aipb_lst_t                       lst;

    // Descriptor fields into the assembler.
    assign bif.kind   = AUDIO_KIND_I;
    assign bif.chan   = CHANNEL_COUNT_I;
    assign bif.acr_fs = ACR_FS_I;
    assign bif.spk    = SPEAKER_MAP_I;
    assign bif.lsv    = LEVEL_SHIFT_I;
    assign bif.dmi    = DOWNMIX_INHIBIT_I;
    assign bif.disc   = DISC_AUDIO_I;

    // Combinational packet assembly from current descriptors.
    aipb_builder u_builder (
        .b (bif.bld)
    );

    // ---------------- Core domain ----------------

    // Decode of the core-side events.
    wire stream_rise = STREAM_ACTIVE_I & ~active_q;
    wire ack_evt     = ack_s ^ ack_seen;
    wire is_idle     = (cst == C_IDLE);
    wire changed     = (bif.pkt != pkt_done);
    wire upd_need    = STREAM_ACTIVE_I & (stream_new | changed); // [R2]
    wire launch      = is_idle & STREAM_ACTIVE_I & (due | upd_need); // [R1] [R2]
    wire hit_sample  = SAMPLE_SENT_I & SAMPLE_NONSILENT_I;
    wire hold_kind   = (AUDIO_KIND_I == AIPB_ONEBIT) | PREFER_HOLD_I;

    // Next values; for due and stream_new a new event beats a clear in the same cycle, but for armed and fcnt the clear wins.
    wire next_due        = (FIELD_START_I & STREAM_ACTIVE_I) | (due & ~launch); // [R1]
    wire next_stream_new = stream_rise | (stream_new & ~ack_evt);
    wire next_armed      = upd_need & (armed | hit_sample);
    wire fcnt_step       = armed & FIELD_START_I & (fcnt != `AIPB_MISS_FIELDS);
    wire [1:0] next_fcnt = ~upd_need ? `AIPB_ZERO2
                         : fcnt_step ? 2'(fcnt + `AIPB_FCNT_ONE)
                         : fcnt;
    wire next_miss       = fcnt_step & (fcnt == `AIPB_FCNT_ONE); // [R2]

    // Launch machine: idle until a send is due, then wait for the link.
    aipb_cst_t next_cst;
    always_comb begin
        next_cst = cst;
        unique case (cst)
            C_IDLE: begin
                if (launch) begin
                    next_cst = C_WAIT;
                end
            end
            C_WAIT: begin
                if (ack_evt) begin
                    next_cst = C_IDLE;
                end
            end
            default: begin
                next_cst = C_IDLE;
            end
        endcase
    end

    // State and flag registers of the core side.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            cst        <= C_IDLE;
            active_q   <= 1'b0;
            stream_new <= 1'b0;
            due        <= 1'b0;
            armed      <= 1'b0;
            fcnt       <= `AIPB_ZERO2;
        end else begin
            cst        <= next_cst;
            active_q   <= STREAM_ACTIVE_I;
            stream_new <= next_stream_new;
            due        <= next_due;
            armed      <= next_armed;
            fcnt       <= next_fcnt;
        end
    end

    // Snapshot the packet at launch and hold it until the link answers.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            pkt_sent <= '0;
            req_tgl  <= 1'b0;
        end else if (launch) begin
            pkt_sent <= bif.pkt;
            req_tgl  <= ~req_tgl;
        end
    end

    // Remember what the sink has really been given.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            pkt_done <= '0;
        end else if (ack_evt) begin
            pkt_done <= pkt_sent;
        end
    end

    // Bring the link's acknowledge toggle into the core clock.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            ack_m    <= 1'b0;
            ack_s    <= 1'b0;
            ack_seen <= 1'b0;
        end else begin
            ack_m    <= ack_tgl;
            ack_s    <= ack_m;
            ack_seen <= ack_s;
        end
    end

    // Status outputs, registered.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            UPDATE_PENDING_O <= 1'b0;
            DEADLINE_MISS_O  <= 1'b0;
            PKT_BUSY_O       <= 1'b0;
        end else begin
            UPDATE_PENDING_O <= upd_need;
            DEADLINE_MISS_O  <= next_miss;
            PKT_BUSY_O       <= (next_cst == C_WAIT);
        end
    end

    // One-bit samples, or all kinds with PREFER_HOLD_I, stall while their describing packet is still undelivered.
    assign SAMPLE_HOLD_O = upd_need & hold_kind; // [R4] [R3]

    // ---------------- Link domain ----------------

    // Reset and request toggle enter the link clock through two flops.
    always_ff @(posedge LINK_CLK_I) begin
        lrst_m <= RESET_I;
        lrst   <= lrst_m;
    end

    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            req_m <= 1'b0;
            req_s <= 1'b0;
        end else begin
            req_m <= req_tgl;
            req_s <= req_m;
        end
    end

    // Decode of the link-side events.
    wire req_evt  = (req_s != req_seen);
    wire is_last  = (idx == `AIPB_LAST_IDX);
    wire emit     = (lst == L_SEND) & ISLAND_OPEN_I; // [R5]
    wire done_pkt = emit & is_last;

    // The snapshot is stable for the whole transfer, so it is read directly.
    wire [7:0] cur_byte = pkt_sent[idx];

    // Byte sender: wait for a packet slot, then stream the bytes.
    aipb_lst_t next_lst;
    always_comb begin
        next_lst = lst;
        unique case (lst)
            L_IDLE: begin
                if (req_evt) begin
                    next_lst = L_WAIT;
                end
            end
            L_WAIT: begin
                if (ISLAND_OPEN_I) begin
                    next_lst = L_SEND; // [R5]
                end
            end
            L_SEND: begin
                if (done_pkt) begin
                    next_lst = L_IDLE;
                end
            end
            default: begin
                next_lst = L_IDLE;
            end
        endcase
    end

    // Link state, byte index and acknowledge toggle.
    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            lst      <= L_IDLE;
            req_seen <= 1'b0;
            idx      <= `AIPB_FIRST_IDX;
            ack_tgl  <= 1'b0;
        end else begin
            lst      <= next_lst;
            req_seen <= req_evt & (lst == L_IDLE) ? req_s : req_seen;
            idx      <= (lst != L_SEND) ? `AIPB_FIRST_IDX
                      : emit ? 5'(idx + 5'h01) : idx;
            ack_tgl  <= ack_tgl ^ done_pkt;
        end
    end

    // Registered byte stream toward the link encoder.
    always_ff @(posedge LINK_CLK_I) begin
        if (lrst) begin
            LINK_VALID_O <= 1'b0;
            LINK_BYTE_O  <= `AIPB_ZERO8;
            LINK_FIRST_O <= 1'b0;
            LINK_LAST_O  <= 1'b0;
        end else begin
            LINK_VALID_O <= emit;
            LINK_BYTE_O  <= emit ? cur_byte : `AIPB_ZERO8;
            LINK_FIRST_O <= emit & (idx == `AIPB_FIRST_IDX);
            LINK_LAST_O  <= done_pkt;
        end
    end

endmodule // aipb_top

/* bench/aipb_checker.sv */
`timescale 1ns/1ps

module aipb_checker (
    input wire logic                 MCLK_I,           // Core clock.
    input wire logic                 RESET_I,          // Reset, high.
    input wire logic                 LINK_CLK_I,       // Link clock.
    input wire logic                 STREAM_ACTIVE_I,  // Stream running.
    input wire aipb_pkg::aipb_kind_t AUDIO_KIND_I,     // Stream kind.
    input wire logic                 PREFER_HOLD_I,    // Hold request.
    input wire logic                 FIELD_START_I,    // Field pulse.
    input wire logic                 SAMPLE_HOLD_O,    // Sample stall.
    input wire logic                 UPDATE_PENDING_O, // Update owed.
    input wire logic                 DEADLINE_MISS_O,  // Late update.
    input wire logic                 PKT_BUSY_O,       // Packet in flight.
    input wire logic                 LINK_VALID_O,     // Byte valid.
    input wire logic [7:0]           LINK_BYTE_O,      // Packet byte.
    input wire logic                 LINK_FIRST_O,     // First byte.
    input wire logic                 LINK_LAST_O       // Last byte.
);
    import aipb_pkg::*;

    logic [4:0] idx;
    logic [7:0] sum;
    logic       mid;

    // A valid byte that is not the first of its packet.
    assign mid = LINK_VALID_O & ~LINK_FIRST_O;

    // Index and running sum of the packet bytes seen so far.
    always_ff @(posedge LINK_CLK_I) begin
        if (RESET_I) begin
            idx <= 5'h00;
            sum <= 8'h00;
        end else if (LINK_VALID_O) begin
            idx <= LINK_FIRST_O ? 5'h01 : idx + 5'h01;
            sum <= LINK_FIRST_O ? LINK_BYTE_O : sum + LINK_BYTE_O;
        end
    end

    property on_link(a, b);
        @(posedge LINK_CLK_I) disable iff (RESET_I) a |-> b;
    endproperty

    chk_hdr_first: assert property (on_link(LINK_FIRST_O,
        LINK_VALID_O && LINK_BYTE_O == 8'h84)) else $error("bad type byte");
    chk_hdr_rest: assert property (on_link(mid && idx < 5'h03,
        LINK_BYTE_O == (idx == 5'h01 ? 8'h01 : 8'h0A))) else $error("bad header byte");
    chk_sum_zero: assert property (on_link(LINK_LAST_O,
        mid && idx == 5'h1E && 8'(sum + LINK_BYTE_O) == 8'h00)) else $error("bad checksum");
    chk_pb1_bits: assert property (on_link(mid && idx == 5'h04,
        LINK_BYTE_O[7:3] == 5'h00)) else $error("bad coding or reserved bit");
    chk_pb2_bits: assert property (on_link(mid && idx == 5'h05,
        LINK_BYTE_O[7:5] == 3'h0 && LINK_BYTE_O[1:0] == 2'h0)) else $error("bad size bits");
    chk_pb_zero: assert property (on_link(mid && (idx == 5'h06 || idx > 5'h08),
        LINK_BYTE_O == 8'h00)) else $error("reserved byte not zero");
    chk_pb5_low: assert property (on_link(mid && idx == 5'h08,
        LINK_BYTE_O[2:0] == 3'h0)) else $error("level byte low bits set");
    // Pending is registered one cycle behind the stall, so each side is checked a cycle apart.
    chk_hold_onebit: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        STREAM_ACTIVE_I && AUDIO_KIND_I == AIPB_ONEBIT && !SAMPLE_HOLD_O |=> !UPDATE_PENDING_O)
        else $error("one-bit samples not held");
    chk_hold_idle: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        SAMPLE_HOLD_O |=> UPDATE_PENDING_O) else $error("hold without update");
    chk_field_send: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        FIELD_START_I && STREAM_ACTIVE_I |-> ##[1:4] PKT_BUSY_O) else $error("no field packet");
    chk_miss_cause: assert property (@(posedge MCLK_I) disable iff (RESET_I)
        DEADLINE_MISS_O |-> $past(UPDATE_PENDING_O)
        && ($past(FIELD_START_I) || $past(FIELD_START_I, 2))) else $error("stray miss");

    // Main scenarios reached.
    cover property (@(posedge LINK_CLK_I) LINK_LAST_O);
    cover property (@(posedge MCLK_I) DEADLINE_MISS_O);
    cover property (@(posedge MCLK_I) SAMPLE_HOLD_O && !PREFER_HOLD_I);

endmodule // aipb_checker

bind aipb_top aipb_checker u_chk (
    .MCLK_I          (MCLK_I),
    .RESET_I         (RESET_I),
    .LINK_CLK_I      (LINK_CLK_I),
    .STREAM_ACTIVE_I (STREAM_ACTIVE_I),
    .AUDIO_KIND_I    (AUDIO_KIND_I),
    .PREFER_HOLD_I   (PREFER_HOLD_I),
    .FIELD_START_I   (FIELD_START_I),
    .SAMPLE_HOLD_O   (SAMPLE_HOLD_O),
    .UPDATE_PENDING_O(UPDATE_PENDING_O),
    .DEADLINE_MISS_O (DEADLINE_MISS_O),
    .PKT_BUSY_O      (PKT_BUSY_O),
    .LINK_VALID_O    (LINK_VALID_O),
    .LINK_BYTE_O     (LINK_BYTE_O),
    .LINK_FIRST_O    (LINK_FIRST_O),
    .LINK_LAST_O     (LINK_LAST_O)
);

/* bench/aipb_sink.sv */
`timescale 1ns/1ps

module aipb_sink (
    input  wire logic        link_clk_i, // Link clock.
    input  wire logic        stall_i,    // Keep islands shut.
    input  wire logic        valid_i,    // Byte valid.
    input  wire logic [7:0]  byte_i,     // Packet byte.
    input  wire logic        first_i,    // First byte.
    input  wire logic        last_i,     // Last byte.
    output logic             island_o,   // Packet slot open.
    output logic [30:0][7:0] pkt_o,      // Last packet taken.
    output int               n_pkt_o     // Packets taken.
);
    logic [1:0] ph;
    logic [4:0] idx;

    // Start with islands shut and nothing received.
    initial begin
        ph = 2'h0;
        idx = 5'h00;
        island_o = 1'b0;
        pkt_o = '0;
        n_pkt_o = 0;
    end

    // Slots open three link cycles in four, so the sender must pause mid-packet.
    always @(posedge link_clk_i) begin
        ph <= ph + 2'h1;
        island_o <= !stall_i && ph != 2'h3;
        if (valid_i) begin
            pkt_o[first_i ? 5'h00 : idx] <= byte_i;
            idx <= first_i ? 5'h01 : idx + 5'h01;
        end
        if (valid_i && last_i) begin
            n_pkt_o <= n_pkt_o + 1;
        end
    end
endmodule // aipb_sink

/* bench/aipb_top_tb.sv */
`timescale 1ns/1ps

module aipb_top_tb;
    import aipb_pkg::*;

    logic mclk, lclk, rst, act, pref, fld, sent, nsil, stall, dmi, disc;
    logic hold, pend, miss, busy, lv, lf, ll, isl;
    aipb_kind_t kind;
    logic [2:0] chan, fs;
    logic [7:0] spk, lb;
    logic [3:0] lsv;
    logic [30:0][7:0] got;
    int n_pkt, n_mismatch, checked;
    int cyc = 0;

    aipb_top dut (.MCLK_I(mclk), .RESET_I(rst), .LINK_CLK_I(lclk), .STREAM_ACTIVE_I(act),
        .AUDIO_KIND_I(kind), .CHANNEL_COUNT_I(chan), .ACR_FS_I(fs), .SPEAKER_MAP_I(spk),
        .LEVEL_SHIFT_I(lsv), .DOWNMIX_INHIBIT_I(dmi), .DISC_AUDIO_I(disc),
        .PREFER_HOLD_I(pref), .FIELD_START_I(fld), .SAMPLE_SENT_I(sent),
        .SAMPLE_NONSILENT_I(nsil), .ISLAND_OPEN_I(isl), .SAMPLE_HOLD_O(hold),
        .UPDATE_PENDING_O(pend), .DEADLINE_MISS_O(miss), .PKT_BUSY_O(busy),
        .LINK_VALID_O(lv), .LINK_BYTE_O(lb), .LINK_FIRST_O(lf), .LINK_LAST_O(ll));

    aipb_sink sink (.link_clk_i(lclk), .stall_i(stall), .valid_i(lv), .byte_i(lb),
        .first_i(lf), .last_i(ll), .island_o(isl), .pkt_o(got), .n_pkt_o(n_pkt));

    // Core clock at 100 ns and link clock at 80 ns with an offset phase.
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    initial begin
        lclk = 1'b0;
        #13;
        forever #40 lclk = ~lclk;
    end

    // Cut a hang short.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (e !== g) begin
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic field();
        fld = 1'b1;
        tick(1);
        fld = 1'b0;
    endtask

    task automatic wait_idle();
        int i;
        tick(2);
        for (i = 0; i < 400 && (pend || busy); i++) tick(1);
        chk("pending and busy", 8'h00, {6'h00, pend, busy});
    endtask

    // Build the packet that the descriptors call for and compare all 31 bytes.
    task automatic cmp_pkt();
        logic [30:0][7:0] e;
        logic [7:0] s;
        int i;
        e = '0;
        s = 8'h00;
        e[0] = 8'h84;
        e[1] = 8'h01;
        e[2] = 8'h0A;
        e[4] = {5'h00, chan};
        e[5] = {3'h0, (kind == AIPB_ONEBIT || kind == AIPB_DST) ? fs : 3'h0, 2'h0};
        e[7] = spk;
        e[8] = {dmi & disc, lsv, 3'h0};
        for (i = 0; i < 31; i++) s = s + e[i];
        e[3] = 8'h00 - s;
        for (i = 0; i < 31; i++) chk($sformatf("byte %0d", i), e[i], got[i]);
    endtask

    // Every stream kind, with rate and inhibit inputs that must be masked or passed.
    task automatic t_kinds();
        int k;
        for (k = 0; k < 4; k++) begin
            kind = aipb_kind_t'(k[1:0]);
            chan = 3'h7 - 3'(k);
            fs = 3'(k) | 3'h2;
            spk = 8'hA5 ^ 8'(k);
            lsv = 4'hF - 4'(k);
            dmi = 1'b1;
            disc = k[0];
            act = 1'b1;
            wait_idle();
            cmp_pkt();
        end
        $display("test kinds done");
    endtask

    // One-bit samples, and any kind under preferred hold, are held while a changed packet is owed.
    task automatic t_hold();
        stall = 1'b1;
        kind = AIPB_ONEBIT;
        chan = 3'h1;
        tick(3);
        chk("hold one-bit", 8'h01, {7'h00, hold});
        kind = AIPB_LPCM;
        tick(1);
        chk("hold pcm", 8'h00, {7'h00, hold});
        pref = 1'b1;
        tick(1);
        chk("hold preferred", 8'h01, {7'h00, hold});
        stall = 1'b0;
        pref = 1'b0;
        wait_idle();
        chk("hold after send", 8'h00, {7'h00, hold});
        cmp_pkt();
        $display("test hold done");
    endtask

    // An update blocked past the second field after an audible sample is late.
    task automatic t_miss();
        logic seen;
        seen = 1'b0;
        stall = 1'b1;
        spk = 8'h3C;
        tick(2);
        sent = 1'b1;
        nsil = 1'b1;
        tick(1);
        sent = 1'b0;
        nsil = 1'b0;
        field();
        tick(10);
        chk("early miss", 8'h00, {7'h00, miss});
        field();
        repeat (3) begin
            seen = seen | miss;
            tick(1);
        end
        chk("deadline miss", 8'h01, {7'h00, seen});
        stall = 1'b0;
        wait_idle();
        cmp_pkt();
        $display("test miss done");
    endtask

    // One packet per field while active, none while idle, one for a new stream.
    task automatic t_repeat();
        int n0;
        n0 = n_pkt;
        repeat (3) begin
            field();
            tick(80);
        end
        chk("field packets", 8'h03, 8'(n_pkt - n0));
        act = 1'b0;
        n0 = n_pkt;
        repeat (2) begin
            field();
            tick(80);
        end
        chk("idle packets", 8'h00, 8'(n_pkt - n0));
        act = 1'b1;
        wait_idle();
        chk("new stream packet", 8'h01, 8'(n_pkt - n0));
        $display("test repeat done");
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Reset for eight cycles, then run the scenarios.
    initial begin
        {act, pref, fld, sent, nsil, stall, dmi, disc} = 8'h00;
        kind = AIPB_LPCM;
        {chan, fs, spk, lsv} = 18'h00000;
        rst = 1'b1;
        n_mismatch = 0;
        checked = 0;
        tick(8);
        rst = 1'b0;
        t_kinds();
        t_hold();
        t_miss();
        t_repeat();
        test_done();
    end
endmodule // aipb_top_tb
